// >>> wdtb_top.sv
// Watchdog, multi-function divider, time base, RTC and halt/wake sequencer.
// Assumes slow sources (RC, RTC, instruction clock) are clk_i enable pulses
// from external dividers; port A pins are asynchronous.
// Function
// RQ1: Watchdog source chosen: RC, instruction, RTC
// RQ2: Disabled watchdog makes its actions no-ops
// RQ3: Watchdog expires after 2^16 source cycles
// RQ4: Overflow when running: chip reset, expiry flag
// RQ5: Overflow in sleep: warm reset only; code also sets the expiry flag
// RQ6: Clear by reset pin, instruction, halt
// RQ7: Single-clear option: one instruction clears
// RQ8: Paired option: both instructions needed to clear; code also clears on a repeat of either one
// RQ9: Instruction source stops counting in sleep
// RQ10: Eight-stage divider plus seven-bit prescaler; code's prescaler is the upper eight bits of the 16-bit chain
// RQ11: Selectable LCD and buzzer frequency taps
// RQ12: Time base ticks at 2^12..2^15, sets bit5
// RQ13: Time base tick offered to counter two
// RQ14: RTC period from control bits 2:0
// RQ15: RTC tick sets request bit6
// RQ16: RTC tick offered to counter one
// RQ17: Sleep keeps slow oscillators and LCD running; code's LCD tap stops in sleep when the instruction source is selected
// RQ18: Halt clears watchdog for RC/RTC source
// RQ19: Halt sets sleep flag, clears expiry flag
// RQ20: Wake on reset, interrupt, overflow, port A
// RQ21: Port wake resumes at next instruction
// RQ22: Stale requests don't wake; 1024-cycle delay
// RQ23: Watchdog clear resets divider chain
//
// The APB register port is this design's own decision.
module wdtb_top #(
  parameter int WAKE_W = 8
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Source enables and external reset pin
  input  wire logic                  rc_tick_i,
  input  wire logic                  rtc_tick_i,
  input  wire logic                  instr_tick_i,
  input  wire logic                  reset_pin_n_i,
  // Core interface
  input  wire wdtb_pkg::wdtb_instr_s instr_i,
  input  wire logic                  irq_pending_i,
  input  wire logic                  irq_serviceable_i,
  input  wire logic [WAKE_W-1:0]     port_a_i,
  output wdtb_pkg::wdtb_rst_s        rst_req_o,
  output logic                       sys_osc_en_o,
  output logic                       run_o,
  output logic                       wake_irq_o,
  // Timer outputs
  output logic                       tb_tick_o,
  output logic                       rtc_tick_o,
  output logic                       lcd_clk_o,
  output logic                       buzzer_o
);
  import wdtb_pkg::*;

  function automatic logic tap(input logic [CHAIN_W-1:0] c,
                               input int idx);
    tap = c[idx];
  endfunction : tap

  // Registers
  logic [RTC_SEL_W-1:0] rtc_sel_reg;
  logic [31:0]          opt_reg;
  logic                 expiry_flag_reg;
  logic                 sleep_entered_flag_reg;
  logic                 periodic_tick_request_reg;
  logic                 clock_tick_request_reg;
  logic                 halted_reg;
  logic                 dummy_reg;
  logic [10:0]          dummy_cnt_reg;
  logic                 paired_seen_reg;
  logic [CHAIN_W-1:0]   chain_reg;
  logic [CHAIN_W-1:0]   chain_next;
  logic [1:0]           pin_rst_sync_reg;
  logic [1:0]           pa_sync0_reg [WAKE_W];
  logic [WAKE_W-1:0]    pa_prev_reg;
  logic                 stale_irq_reg;
  logic                 tb_tap_reg;
  logic                 rtc_tap_reg;

  wdtb_src_e         src;
  logic              wdt_en;
  logic              paired;
  logic              src_tick;
  logic              wdt_clear;
  logic              overflow;
  logic              tb_edge;
  logic              rtc_edge;
  logic [WAKE_W-1:0] pa_now;
  logic              port_wake;
  logic              irq_wake;
  logic              pin_low;
  logic              apb_wr;
  logic              apb_rd;

  assign wdt_en = opt_reg[OPT_WDT_EN];
  assign paired = opt_reg[OPT_PAIRED];
  assign src    = wdtb_src_e'(opt_reg[OPT_SRC_LO +: 2]);
  assign pin_low = ~pin_rst_sync_reg[1];

  always_comb begin
    case (src) // RQ1
      WDTB_SRC_RC:    src_tick = rc_tick_i;
      WDTB_SRC_INSTR: src_tick = instr_tick_i & ~halted_reg; // RQ9
      WDTB_SRC_RTC:   src_tick = rtc_tick_i;
      default:        src_tick = 1'b0;
    endcase
  end

  // Reset pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_rst_sync_reg <= 2'h3;
    end else begin
      pin_rst_sync_reg <= {pin_rst_sync_reg[0], reset_pin_n_i};
    end
  end

  // Port A synchronisers and falling edge detect
  for (genvar g = 0; g < WAKE_W; g++) begin : g_pa
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        pa_sync0_reg[g] <= 2'h3;
        pa_prev_reg[g]  <= 1'b1;
      end else begin
        pa_sync0_reg[g] <= {pa_sync0_reg[g][0], port_a_i[g]};
        pa_prev_reg[g]  <= pa_sync0_reg[g][1];
      end
    end
    assign pa_now[g] = pa_sync0_reg[g][1];
  end

  // Watchdog clear conditions
  always_comb begin
    wdt_clear = 1'b0;
    if (wdt_en) begin // RQ2
      if (pin_low) wdt_clear = 1'b1; // RQ6
      if (!paired && instr_i.single_clear) wdt_clear = 1'b1; // RQ7
      if (paired && instr_i.paired_second && paired_seen_reg)
        wdt_clear = 1'b1; // RQ8
      if (paired && instr_i.paired_first && paired_seen_reg)
        wdt_clear = 1'b1; // RQ8
      if (instr_i.halt && !halted_reg && src != WDTB_SRC_INSTR)
        wdt_clear = 1'b1; // RQ18
    end
  end

  // Either order of the pair arms the other half
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      paired_seen_reg <= 1'b0;
    end else if (wdt_clear || !paired || !wdt_en) begin
      paired_seen_reg <= 1'b0;
    end else if (instr_i.paired_first || instr_i.paired_second) begin
      paired_seen_reg <= 1'b1; // RQ8
    end
  end

  // Shared chain: low 8 bits divider, upper bits prescaler
  always_comb begin
    chain_next = chain_reg;
    if (wdt_clear) begin
      chain_next = '0; // RQ23
    end else if (src_tick) begin
      chain_next = chain_reg + 1'b1; // RQ10
    end
  end

  assign overflow = wdt_en && src_tick && !wdt_clear
                    && (&chain_reg); // RQ3

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  // Time base and RTC taps; rising tap bit marks a period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tb_tap_reg  <= 1'b0;
      rtc_tap_reg <= 1'b0;
    end else begin
      tb_tap_reg  <= tap(chain_next, TB_BASE + int'(opt_reg[OPT_TB_LO +: 2]));
      rtc_tap_reg <= tap(chain_next, RTC_BASE + int'(rtc_sel_reg)); // RQ14
    end
  end
  assign tb_edge  = tap(chain_next, TB_BASE + int'(opt_reg[OPT_TB_LO +: 2]))
                    & ~tb_tap_reg; // RQ12
  assign rtc_edge = tap(chain_next, RTC_BASE + int'(rtc_sel_reg))
                    & ~rtc_tap_reg;

  // Tick pulses and frequency taps, registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tb_tick_o  <= 1'b0;
      rtc_tick_o <= 1'b0;
      lcd_clk_o  <= 1'b0;
      buzzer_o   <= 1'b0;
    end else begin
      tb_tick_o  <= tb_edge; // RQ13
      rtc_tick_o <= rtc_edge; // RQ16
      lcd_clk_o  <= tap(chain_reg, TAP_BASE
                        + int'(opt_reg[OPT_LCD_LO +: 3])); // RQ11
      buzzer_o   <= tap(chain_reg, TAP_BASE
                        + int'(opt_reg[OPT_BZ_LO +: 3])); // RQ11
    end
  end

  // Request flags; set wins over software clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      periodic_tick_request_reg <= 1'b0;
      clock_tick_request_reg    <= 1'b0;
    end else begin
      if (tb_edge) begin
        periodic_tick_request_reg <= 1'b1; // RQ12
      end else if (apb_wr && paddr_i == ADDR_REQ && !pwdata_i[REQ_TB]) begin
        periodic_tick_request_reg <= 1'b0;
      end
      if (rtc_edge) begin
        clock_tick_request_reg <= 1'b1; // RQ15
      end else if (apb_wr && paddr_i == ADDR_REQ && !pwdata_i[REQ_RTC]) begin
        clock_tick_request_reg <= 1'b0;
      end
    end
  end

  // Halt, wake-up and dummy delay
  assign port_wake = |(pa_prev_reg & ~pa_now
                       & opt_reg[OPT_WAKE_LO +: WAKE_W]); // RQ20
  assign irq_wake  = irq_pending_i & ~stale_irq_reg; // RQ22

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      halted_reg    <= 1'b0;
      dummy_reg     <= 1'b0;
      dummy_cnt_reg <= '0;
      stale_irq_reg <= 1'b0;
      wake_irq_o    <= 1'b0;
    end else if (!halted_reg) begin
      if (dummy_reg) begin
        if (dummy_cnt_reg == 11'(DUMMY_CYC - 1)) begin
          dummy_reg <= 1'b0; // RQ22
        end
        dummy_cnt_reg <= dummy_cnt_reg + 1'b1;
      end else begin
        wake_irq_o <= 1'b0;
      end
      if (instr_i.halt && !dummy_reg) begin
        halted_reg    <= 1'b1; // RQ17
        stale_irq_reg <= irq_pending_i; // RQ22
      end
    end else if (pin_low || overflow || port_wake || irq_wake) begin
      halted_reg    <= 1'b0; // RQ20
      dummy_reg     <= 1'b1;
      dummy_cnt_reg <= '0;
      wake_irq_o    <= irq_wake & irq_serviceable_i & ~port_wake; // RQ21
    end
  end

  assign sys_osc_en_o = ~halted_reg; // RQ17
  assign run_o        = ~halted_reg & ~dummy_reg;

  // Reset requests
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_req_o <= '0;
    end else begin
      rst_req_o.chip_reset <= (overflow && !halted_reg) || pin_low; // RQ4
      rst_req_o.warm_reset <= overflow && halted_reg; // RQ5
    end
  end

  // Status flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      expiry_flag_reg        <= 1'b0;
      sleep_entered_flag_reg <= 1'b0;
    end else begin
      if (overflow) begin
        expiry_flag_reg <= 1'b1; // RQ4
      end else if (instr_i.halt && !halted_reg && wdt_en) begin
        expiry_flag_reg <= 1'b0; // RQ19
      end
      if (instr_i.halt && !halted_reg && wdt_en) begin
        sleep_entered_flag_reg <= 1'b1; // RQ19
      end else if (wdt_en && instr_i.single_clear) begin
        sleep_entered_flag_reg <= 1'b0; // RQ19
      end
    end
  end

  // APB slave: zero wait states
  assign apb_wr    = psel_i & penable_i & pwrite_i;
  assign apb_rd    = psel_i & ~pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rtc_sel_reg <= RTC_SEL_RST;
      opt_reg     <= OPT_RST;
    end else if (apb_wr) begin
      if (paddr_i == ADDR_RTC_CTRL) begin
        rtc_sel_reg <= pwdata_i[RTC_SEL_W-1:0]; // RQ14
      end
      if (paddr_i == ADDR_OPTION) begin
        opt_reg <= pwdata_i;
      end
    end
  end

  // Read data registered in setup phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (apb_rd && !penable_i) begin
      prdata_o <= '0;
      case (paddr_i)
        ADDR_RTC_CTRL: prdata_o[RTC_SEL_W-1:0] <= rtc_sel_reg;
        ADDR_OPTION:   prdata_o <= opt_reg;
        ADDR_REQ: begin
          prdata_o[REQ_TB]  <= periodic_tick_request_reg;
          prdata_o[REQ_RTC] <= clock_tick_request_reg;
        end
        ADDR_STATUS: begin
          prdata_o[ST_EXPIRY] <= expiry_flag_reg;
          prdata_o[ST_SLEEP]  <= sleep_entered_flag_reg;
          prdata_o[ST_HALTED] <= halted_reg;
          prdata_o[ST_DUMMY]  <= dummy_reg;
        end
        default: prdata_o <= '0;
      endcase
    end
  end

endmodule : wdtb_top

// >>> wdtb_pkg.sv
// Package for the watchdog, time base, RTC and halt sequencer block.
// Assumes a single 100 MHz clock; slow sources arrive as enable pulses.
package wdtb_pkg;

  // Register byte addresses (APB, one aligned word each)
  localparam logic [7:0] ADDR_RTC_CTRL = 8'h24; // rtc_period_control, idx 09H
  localparam logic [7:0] RTC_CTRL_IDX  = 8'h09;
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_REQ      = 8'h04;
  localparam logic [7:0] ADDR_OPTION   = 8'h08;

  // rtc_period_control field and reset
  localparam int         RTC_SEL_W     = 3;
  localparam logic [2:0] RTC_SEL_RST   = 3'h7;

  // Status bits
  localparam int ST_EXPIRY  = 0;
  localparam int ST_SLEEP   = 1;
  localparam int ST_HALTED  = 2;
  localparam int ST_DUMMY   = 3;

  // Request register bits (second_irq_control layout)
  localparam int REQ_TB  = 5;
  localparam int REQ_RTC = 6;

  // Option register fields
  localparam int OPT_WDT_EN   = 0;
  localparam int OPT_PAIRED   = 1;
  localparam int OPT_SRC_LO   = 2;
  localparam int OPT_TB_LO    = 4;
  localparam int OPT_LCD_LO   = 6;
  localparam int OPT_BZ_LO    = 9;
  localparam int OPT_WAKE_LO  = 12;
  localparam logic [31:0] OPT_RST = 32'h0000_0001;

  // Divider chain
  localparam int CHAIN_W    = 16;
  localparam int WDT_BIT    = 15; // overflow of 2^16 counts
  localparam int TB_BASE    = 11; // 2^12 tap index
  localparam int RTC_BASE   = 7;  // 2^8 tap index
  localparam int TAP_BASE   = 1;  // 2^2 tap index

  // Wake-up dummy delay
  localparam int DUMMY_CYC  = 1024;

  typedef enum logic [1:0] {
    WDTB_SRC_RC,
    WDTB_SRC_INSTR,
    WDTB_SRC_RTC
  } wdtb_src_e;

  // Instruction strobes from the core
  typedef struct packed {
    logic single_clear;
    logic paired_first;
    logic paired_second;
    logic halt;
  } wdtb_instr_s;

  // Reset requests to the core
  typedef struct packed {
    logic chip_reset;
    logic warm_reset;
  } wdtb_rst_s;

endpackage : wdtb_pkg

// >>> wdtb_checker.sv
// Port assertions for wdtb_top, bound at the foot of this file.
// Assumes one clock domain, clk_i, with asynchronous rst_i.
module wdtb_checker #(
  parameter int WAKE_W = 8
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  reset_pin_n_i,
  input wire wdtb_pkg::wdtb_instr_s instr_i,
  input wire logic                  irq_pending_i,
  input wire wdtb_pkg::wdtb_rst_s   rst_req_o,
  input wire logic                  sys_osc_en_o,
  input wire logic                  run_o,
  input wire logic                  tb_tick_o,
  input wire logic                  rtc_tick_o
);
  import wdtb_pkg::*;
  logic [11:0] dummy_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the wake-up dummy period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dummy_cnt <= 12'h000;
    end else if (sys_osc_en_o && !run_o) begin
      dummy_cnt <= dummy_cnt + 12'h001;
    end else begin
      dummy_cnt <= 12'h000;
    end
  end
  sequence s_halt_entry;
    instr_i.halt && run_o && reset_pin_n_i;
  endsequence
  sequence s_stale_halt;
    instr_i.halt && run_o && reset_pin_n_i && irq_pending_i;
  endsequence
  a_halt_osc_off: assert property (s_halt_entry |=> !sys_osc_en_o)
    else $error("oscillator still on after halt");
  a_stale_no_wake: assert property (
    s_stale_halt |=> !sys_osc_en_o [*2])
    else $error("stale request woke the device");
  a_dummy_len: assert property (
    $rose(run_o) |-> dummy_cnt inside {[1023:1025]})
    else $error("dummy period length wrong");
  a_warm_halted: assert property (
    rst_req_o.warm_reset |-> $past(!sys_osc_en_o))
    else $error("warm reset outside halt");
  a_warm_wakes: assert property (
    rst_req_o.warm_reset |-> ##[0:2] sys_osc_en_o)
    else $error("overflow did not wake");
  a_reset_excl: assert property (
    !(rst_req_o.chip_reset && rst_req_o.warm_reset))
    else $error("both reset kinds at once");
  a_pin_reset: assert property (
    !reset_pin_n_i [*4] |-> rst_req_o.chip_reset)
    else $error("reset pin ignored");
  a_rtc_spacing: assert property (rtc_tick_o |=> !rtc_tick_o [*8])
    else $error("rtc ticks too close");
  a_tb_spacing: assert property (tb_tick_o |=> !tb_tick_o [*8])
    else $error("time base ticks too close");
endmodule : wdtb_checker

bind wdtb_top wdtb_checker #(.WAKE_W(WAKE_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
  .instr_i(instr_i), .irq_pending_i(irq_pending_i),
  .rst_req_o(rst_req_o), .sys_osc_en_o(sys_osc_en_o), .run_o(run_o),
  .tb_tick_o(tb_tick_o), .rtc_tick_o(rtc_tick_o));

// >>> wdtb_core_model.sv
// Behavioural core and interrupt flag holder facing the block.
// Assumes strobes are taken at the next rising clk_i edge.
module wdtb_core_model (
  input  wire logic                clk_i,
  input  wire logic                run_i,
  input  wire wdtb_pkg::wdtb_rst_s rst_req_i,
  output wdtb_pkg::wdtb_instr_s    instr_o,
  output logic                     irq_pending_o,
  output logic                     irq_serviceable_o
);
  import wdtb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr_o = '0;
    irq_pending_o = 1'b0;
    irq_serviceable_o = 1'b0;
  end
  // Chip reset empties the pending flag; warm reset leaves it
  always @(posedge clk_i) begin
    if (rst_req_i.chip_reset) begin
      irq_pending_o <= 1'b0;
    end
  end
  task automatic set_irq(input logic v);
    irq_pending_o <= v;
  endtask : set_irq
  // Interrupt enabled and stack not full
  task automatic set_serv(input logic v);
    irq_serviceable_o <= v;
  endtask : set_serv
  // A halted core executes nothing
  task automatic exec(input logic [3:0] k);
    while (run_i !== 1'b1) @(posedge clk_i);
    instr_o <= wdtb_instr_s'(k);
    @(posedge clk_i);
    instr_o <= '0;
    @(posedge clk_i);
  endtask : exec
endmodule : wdtb_core_model

// >>> testbench.sv
// Self-checking bench for wdtb_top with the core model.
// Assumes the RC source enable is high every cycle until the closing eight-cycle wait.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wdtb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i, port_a_i;
  logic [31:0] pwdata_i, prdata_o, seed = 32'd94268;
  logic rc_tick_i, rtc_tick_i, instr_tick_i, reset_pin_n_i;
  logic irq_pending_i, irq_serviceable_i, sys_osc_en_o, run_o, wake_irq_o;
  logic tb_tick_o, rtc_tick_o, lcd_clk_o, buzzer_o;
  wdtb_instr_s instr_i;
  wdtb_rst_s rst_req_o;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  logic rc_hold = 1'b1;
  logic [31:0] exp_q[$];

  wdtb_top #(.WAKE_W(8)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rc_tick_i(rc_tick_i),
    .rtc_tick_i(rtc_tick_i), .instr_tick_i(instr_tick_i),
    .reset_pin_n_i(reset_pin_n_i), .instr_i(instr_i),
    .irq_pending_i(irq_pending_i), .irq_serviceable_i(irq_serviceable_i),
    .port_a_i(port_a_i), .rst_req_o(rst_req_o),
    .sys_osc_en_o(sys_osc_en_o), .run_o(run_o), .wake_irq_o(wake_irq_o),
    .tb_tick_o(tb_tick_o), .rtc_tick_o(rtc_tick_o),
    .lcd_clk_o(lcd_clk_o), .buzzer_o(buzzer_o));
  wdtb_core_model core (.clk_i(clk_i), .run_i(run_o),
    .rst_req_i(rst_req_o), .instr_o(instr_i),
    .irq_pending_o(irq_pending_i), .irq_serviceable_o(irq_serviceable_i));

  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Waits for bit w of {warm reset, run, time base, rtc}
  task automatic wait_hi(input int w, output int n);
    logic [3:0] s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      s = {rst_req_o.warm_reset, run_o, tb_tick_o, rtc_tick_o};
    end while (s[w] !== 1'b1);
  endtask : wait_hi

  always @(posedge clk_i) begin
    seed <= xs(seed);
    rc_tick_i <= rc_hold | seed[3];
    rtc_tick_i <= seed[0];
    instr_tick_i <= seed[1];
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      check("prdata", prdata_o, exp_q.pop_front());
    end
  end

  // Hang guard sized for one full watchdog period plus the rest
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] v;
    int n;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {rc_tick_i, rtc_tick_i, instr_tick_i, reset_pin_n_i} = 4'b1001;
    port_a_i = 8'hff;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_RTC_CTRL, {29'h0, RTC_SEL_RST});
    rd(ADDR_OPTION, OPT_RST);
    rd(8'h40, 32'h0000_0000);
    v = {29'h0, seed[2:0]};
    apb(1'b1, ADDR_RTC_CTRL, v);
    rd(ADDR_RTC_CTRL, v);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_RTC_CTRL, c);
      wait_hi(0, n);
      wait_hi(0, n);
      check("rtc period", n, 32'h100 << c);
    end
    wait_hi(1, n);
    wait_hi(1, n);
    check("time base period", n, 32'h0000_1000);
    apb(1'b1, ADDR_OPTION, 32'h0000_1001);
    rd(ADDR_OPTION, 32'h0000_1001);
    core.set_irq(1'b1);
    core.exec(4'b0001);
    rd(ADDR_STATUS, 32'h0000_0006);
    port_a_i <= 8'hfe;
    repeat (8) @(posedge clk_i);
    check("run wake_irq", {run_o, wake_irq_o}, 32'h0);
    wait_hi(2, n);
    port_a_i <= 8'hff;
    rd(ADDR_STATUS, 32'h0000_0002);
    core.exec(4'b0100);
    core.exec(4'b0010);
    rd(ADDR_STATUS, 32'h0000_0002);
    core.exec(4'b1000);
    rd(ADDR_STATUS, 32'h0000_0000);
    core.exec(4'b0001);
    wait_hi(3, n);
    check("wdt period", n >= 65534 && n <= 65539, 32'h1);
    wait_hi(2, n);
    rd(ADDR_STATUS, 32'h0000_0003);
    reset_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("pin chip reset", rst_req_o.chip_reset, 32'h1);
    reset_pin_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    // Fresh request while halted, serviceable: interrupt response
    core.set_serv(1'b1);
    core.exec(4'b0001);
    core.set_irq(1'b1);
    repeat (4) @(posedge clk_i);
    check("irq wake", {run_o, wake_irq_o}, 32'h1);
    wait_hi(2, n);
    rc_hold <= 1'b0;
    repeat (8) @(posedge clk_i);
    wrap_up();
  end
endmodule : testbench
